// >>> tcon_two_pkg.sv
// package: offsets, fields, reset values and carriers of the second timer control block
package tcon_two_pkg;

	// =====================================================
	// register indices (byte address is four times index)
	localparam logic [4:0] IDX_TIMER_CONTROL_SECOND = 5'h17;
	localparam logic [4:0] IDX_EVENT_STATUS = 5'h18;
	localparam logic [4:0] IDX_EVENT_MASK = 5'h19;
	localparam logic [4:0] IDX_PORT_CONFIG = 5'h1A;
	localparam logic [4:0] IDX_SECOND_CAPTURE_LOW = 5'h1B;
	localparam logic [4:0] IDX_SECOND_CAPTURE_HIGH = 5'h1C;
	localparam logic [4:0] IDX_SHARED_PAIR_LOW = 5'h1D;
	localparam logic [4:0] IDX_SHARED_PAIR_HIGH = 5'h1E;

	// =====================================================
	// control register field positions
	localparam int BIT_SECOND_OVERRUN = 7;
	localparam int BIT_FIRST_OVERRUN = 6;
	localparam int BIT_SECOND_PULSE_EN = 5;
	localparam int BIT_FIRST_PULSE_EN = 4;
	localparam int BIT_CAPTURE_SELECT = 3;
	localparam int BIT_TIMER_THREE_RUN = 2;
	localparam int BIT_TIMER_TWO_RUN = 1;
	localparam int BIT_TIMER_ONE_RUN = 0;
	// bits that software may write in the control register
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h3F;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// =====================================================
	// event status / mask field positions
	localparam int EV_FIRST_CAPTURE = 0;
	localparam int EV_SECOND_CAPTURE = 1;
	localparam int EV_FIRST_OVERRUN = 2;
	localparam int EV_SECOND_OVERRUN = 3;
	localparam int EV_WIDTH = 4;
	localparam logic [3:0] EV_RESET = 4'h0;

	// =====================================================
	// port configuration field positions
	localparam int CFG_PAIR_SIXTEEN = 0;
	localparam int CFG_FIRST_DIR = 2;
	localparam int CFG_SECOND_DIR = 3;
	localparam int CFG_FIRST_PIN_LEVEL = 4;
	localparam int CFG_SECOND_PIN_LEVEL = 5;
	localparam int CFG_FIRST_LATCH = 6;
	localparam int CFG_SECOND_LATCH = 7;
	// direction bits reset to input, latches and mode to zero
	localparam logic [7:0] CFG_RESET = 8'h0C;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hCD;

	// shared pair reset value
	localparam logic [15:0] PAIR_RESET = 16'h0000;

	// =====================================================
	// capture pair state carrier
	typedef struct packed {
		logic [15:0] value;
		logic unread;
		logic lowRead;
		logic highRead;
		logic overrun;
	} capture_pair_t;

	localparam capture_pair_t CAPTURE_RESET = '{16'h0000, 1'b0, 1'b0, 1'b0, 1'b0};

	// timer gating outputs carrier
	typedef struct packed {
		logic timerOneInc;
		logic timerTwoInc;
		logic timerThreeInc;
		logic periodLimit;
	} timer_gate_t;

endpackage

// >>> timer_capture_pwm_control.sv
// module: second timer control register with capture overrun and pulse pin steering
// Function
// - second capture overrun flag on unread capture
// - second pair keeps oldest value until read
// - first capture overrun flag and hold likewise
// - second pulse enable overrides pin direction
// - first pulse enable overrides pin direction
// - select one: shared pair captures, no period
// - select zero: shared pair is period register
// - timer three counts only while run set
// - timer two run gates timer two increments
// - sixteen-bit mode: timer one run gates pair
// - eight-bit mode: timer one run gates timer one
// - pair mode bit joins timers one and two
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none

module timer_capture_pwm_control
	import tcon_two_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [6:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// capture events and timer three value from timer logic
	input wire logic firstCaptureEvent,
	input wire logic secondCaptureEvent,
	input wire logic [15:0] timerThreeCount,
	// pulse waveforms from pwm logic
	input wire logic firstPulseLevel,
	input wire logic secondPulseLevel,
	// timer gating and period towards counters
	output timer_gate_t timerGate,
	output logic [15:0] timerThreePeriod,
	// first pulse output pin
	input wire logic firstPulsePinIn,
	output logic firstPulsePinOut,
	output logic firstPulsePinOe_n,
	// second pulse output pin
	input wire logic secondPulsePinIn,
	output logic secondPulsePinOut,
	output logic secondPulsePinOe_n,
	// interrupt
	output logic irq
);

	// =====================================================
	// declarations
	logic [7:0] ctrl_ff; // control bits 5..0 stored here
	logic [7:0] cfg_ff; // pair mode, directions, latches
	logic [3:0] status_ff; // sticky event bits
	logic [3:0] mask_ff; // event enables
	capture_pair_t capOne_ff; // shared pair as capture
	capture_pair_t capTwo_ff; // second capture pair
	logic [15:0] period_ff; // shared pair as period
	logic ack_ff; // answer phase of a bus access
	logic [31:0] readdata_ff; // registered read data
	logic [1:0] pinSync1_ff; // first sync stage of pin levels
	logic [1:0] pinSync2_ff; // second sync stage
	logic [4:0] index; // register index of access
	logic req; // bus request present
	logic accept; // access completes this edge
	logic wrCtrl; // write control register
	logic wrCfg; // write configuration
	logic wrStatus; // write-one-to-clear status
	logic wrMask; // write mask
	logic wrPairLow; // write period low byte
	logic wrPairHigh; // write period high byte
	logic rdTwoLow; // read second pair low
	logic rdTwoHigh; // read second pair high
	logic rdOneLow; // read shared pair low
	logic rdOneHigh; // read shared pair high
	logic captureSelect; // shared pair used for capture
	logic firstTaken; // first capture latched value
	logic secondTaken; // second capture latched value
	logic firstOverrun; // first capture found pair unread
	logic secondOverrun; // second capture found pair unread
	logic [3:0] events; // event pulses for status
	logic [7:0] ctrlView; // control register as read
	logic [7:0] cfgView; // configuration as read
	logic [31:0] nxt_readdata; // read mux

	// =====================================================
	// bus decode
	assign index = address[6:2];
	assign req = read | write;
	assign accept = req & ack_ff;
	// one wait cycle on every access
	assign waitrequest = req & ~ack_ff;
	assign readdata = readdata_ff;

	assign wrCtrl = accept & write & byteenable[0] & (index == IDX_TIMER_CONTROL_SECOND);
	assign wrCfg = accept & write & byteenable[0] & (index == IDX_PORT_CONFIG);
	assign wrStatus = accept & write & byteenable[0] & (index == IDX_EVENT_STATUS);
	assign wrMask = accept & write & byteenable[0] & (index == IDX_EVENT_MASK);
	assign wrPairLow = accept & write & byteenable[0] & (index == IDX_SHARED_PAIR_LOW);
	assign wrPairHigh = accept & write & byteenable[0] & (index == IDX_SHARED_PAIR_HIGH);
	assign rdTwoLow = accept & read & (index == IDX_SECOND_CAPTURE_LOW);
	assign rdTwoHigh = accept & read & (index == IDX_SECOND_CAPTURE_HIGH);
	assign rdOneLow = accept & read & (index == IDX_SHARED_PAIR_LOW);
	assign rdOneHigh = accept & read & (index == IDX_SHARED_PAIR_HIGH);

	// answer phase toggles so every access takes two edges
	always_ff @(posedge mclk)
	begin
		if (srst)
			ack_ff <= 1'b0;
		else
			ack_ff <= req & ~ack_ff;
	end

	// =====================================================
	// register views
	always_comb
	begin
		ctrlView = ctrl_ff & CTRL_WRITE_MASK;
		ctrlView[BIT_SECOND_OVERRUN] = capTwo_ff.overrun;
		ctrlView[BIT_FIRST_OVERRUN] = capOne_ff.overrun;
		cfgView = cfg_ff & CFG_WRITE_MASK;
		cfgView[CFG_FIRST_PIN_LEVEL] = pinSync2_ff[0];
		cfgView[CFG_SECOND_PIN_LEVEL] = pinSync2_ff[1];
	end

	// read mux; unmapped indices read zero
	always_comb
	begin
		nxt_readdata = 32'h00000000;
		unique case (index)
			IDX_TIMER_CONTROL_SECOND: nxt_readdata[7:0] = ctrlView;
			IDX_EVENT_STATUS: nxt_readdata[3:0] = status_ff;
			IDX_EVENT_MASK: nxt_readdata[3:0] = mask_ff;
			IDX_PORT_CONFIG: nxt_readdata[7:0] = cfgView;
			IDX_SECOND_CAPTURE_LOW: nxt_readdata[7:0] = capTwo_ff.value[7:0];
			IDX_SECOND_CAPTURE_HIGH: nxt_readdata[7:0] = capTwo_ff.value[15:8];
			// shared pair shows capture or period by mode
			IDX_SHARED_PAIR_LOW:
				nxt_readdata[7:0] = captureSelect ? capOne_ff.value[7:0] : period_ff[7:0];
			IDX_SHARED_PAIR_HIGH:
				nxt_readdata[7:0] = captureSelect ? capOne_ff.value[15:8] : period_ff[15:8];
			default: nxt_readdata = 32'h00000000;
		endcase
	end

	// read data captured in the wait cycle, held through answer
	always_ff @(posedge mclk)
	begin
		if (srst)
			readdata_ff <= 32'h00000000;
		else if (req & ~ack_ff & read)
			readdata_ff <= nxt_readdata;
	end

	// =====================================================
	// control and configuration registers
	// control clears at reset
	always_ff @(posedge mclk)
	begin
		if (srst)
			ctrl_ff <= CTRL_RESET;
		else if (wrCtrl)
			ctrl_ff <= writedata[7:0] & CTRL_WRITE_MASK;
	end

	// pair mode, directions and pin latches
	always_ff @(posedge mclk)
	begin
		if (srst)
			cfg_ff <= CFG_RESET;
		else if (wrCfg)
			cfg_ff <= writedata[7:0] & CFG_WRITE_MASK;
	end

	// period register halves written by software
	always_ff @(posedge mclk)
	begin
		if (srst)
			period_ff <= PAIR_RESET;
		else if (wrPairLow)
			period_ff[7:0] <= writedata[7:0];
		else if (wrPairHigh)
			period_ff[15:8] <= writedata[7:0];
	end

	// =====================================================
	// capture pairs
	assign captureSelect = ctrl_ff[BIT_CAPTURE_SELECT];
	// first capture only in capture mode
	assign firstTaken = firstCaptureEvent & captureSelect & ~capOne_ff.unread;
	assign firstOverrun = firstCaptureEvent & captureSelect & capOne_ff.unread;
	assign secondTaken = secondCaptureEvent & ~capTwo_ff.unread;
	assign secondOverrun = secondCaptureEvent & capTwo_ff.unread;

	// second pair: latch, track byte reads, flag overrun
	always_ff @(posedge mclk)
	begin
		if (srst)
			capTwo_ff <= CAPTURE_RESET;
		else if (secondTaken)
		begin
			capTwo_ff.value <= timerThreeCount;
			capTwo_ff.unread <= 1'b1;
			capTwo_ff.lowRead <= 1'b0;
			capTwo_ff.highRead <= 1'b0;
		end
		else if (secondOverrun)
			capTwo_ff.overrun <= 1'b1;
		// value held until both bytes read
		else if ((capTwo_ff.lowRead | rdTwoLow) & (capTwo_ff.highRead | rdTwoHigh))
		begin
			capTwo_ff.unread <= 1'b0;
			capTwo_ff.lowRead <= 1'b0;
			capTwo_ff.highRead <= 1'b0;
			capTwo_ff.overrun <= 1'b0;
		end
		else
		begin
			capTwo_ff.lowRead <= capTwo_ff.lowRead | rdTwoLow;
			capTwo_ff.highRead <= capTwo_ff.highRead | rdTwoHigh;
		end
	end

	// first pair: same scheme on the shared register pair
	always_ff @(posedge mclk)
	begin
		if (srst)
			capOne_ff <= CAPTURE_RESET;
		else if (firstTaken)
		begin
			capOne_ff.value <= timerThreeCount;
			capOne_ff.unread <= 1'b1;
			capOne_ff.lowRead <= 1'b0;
			capOne_ff.highRead <= 1'b0;
		end
		// overrun flag and hold oldest value
		else if (firstOverrun)
			capOne_ff.overrun <= 1'b1;
		else if ((capOne_ff.lowRead | rdOneLow) & (capOne_ff.highRead | rdOneHigh))
		begin
			capOne_ff.unread <= 1'b0;
			capOne_ff.lowRead <= 1'b0;
			capOne_ff.highRead <= 1'b0;
			capOne_ff.overrun <= 1'b0;
		end
		else
		begin
			capOne_ff.lowRead <= capOne_ff.lowRead | rdOneLow;
			capOne_ff.highRead <= capOne_ff.highRead | rdOneHigh;
		end
	end

	// =====================================================
	// interrupt status and mask
	always_comb
	begin
		events = 4'h0;
		events[EV_FIRST_CAPTURE] = firstTaken;
		events[EV_SECOND_CAPTURE] = secondTaken;
		events[EV_FIRST_OVERRUN] = firstOverrun;
		events[EV_SECOND_OVERRUN] = secondOverrun;
	end

	// sticky bits; a new event wins over a clearing write
	always_ff @(posedge mclk)
	begin
		if (srst)
			status_ff <= EV_RESET;
		else if (wrStatus)
			status_ff <= (status_ff & ~writedata[3:0]) | events;
		else
			status_ff <= status_ff | events;
	end

	// event mask
	always_ff @(posedge mclk)
	begin
		if (srst)
			mask_ff <= EV_RESET;
		else if (wrMask)
			mask_ff <= writedata[3:0];
	end

	assign irq = |(status_ff & mask_ff);

	// =====================================================
	// timer gating
	always_comb
	begin
		// sixteen-bit pair follows timer one run
		// eight-bit timer one follows its run bit
		timerGate.timerOneInc = ctrl_ff[BIT_TIMER_ONE_RUN];
		// pair mode chains timer two to timer one
		// timer two run gates its increments
		if (cfg_ff[CFG_PAIR_SIXTEEN])
			timerGate.timerTwoInc = ctrl_ff[BIT_TIMER_ONE_RUN] & ctrl_ff[BIT_TIMER_TWO_RUN];
		else
			timerGate.timerTwoInc = ctrl_ff[BIT_TIMER_TWO_RUN];
		// timer three runs only while enabled
		timerGate.timerThreeInc = ctrl_ff[BIT_TIMER_THREE_RUN];
		// period limit only in period mode
		timerGate.periodLimit = ~captureSelect;
	end

	assign timerThreePeriod = period_ff;

	// =====================================================
	// pulse pins
	// two-flop synchroniser for the pin levels
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pinSync1_ff <= 2'h0;
			pinSync2_ff <= 2'h0;
		end
		else
		begin
			pinSync1_ff <= {secondPulsePinIn, firstPulsePinIn};
			pinSync2_ff <= pinSync1_ff;
		end
	end

	// first enable drives pin, else direction bit
	assign firstPulsePinOe_n = ctrl_ff[BIT_FIRST_PULSE_EN] ? 1'b0 : cfg_ff[CFG_FIRST_DIR];
	assign firstPulsePinOut = ctrl_ff[BIT_FIRST_PULSE_EN] ? firstPulseLevel
		: cfg_ff[CFG_FIRST_LATCH];
	// second enable drives pin, else direction bit
	assign secondPulsePinOe_n = ctrl_ff[BIT_SECOND_PULSE_EN] ? 1'b0 : cfg_ff[CFG_SECOND_DIR];
	assign secondPulsePinOut = ctrl_ff[BIT_SECOND_PULSE_EN] ? secondPulseLevel
		: cfg_ff[CFG_SECOND_LATCH];

endmodule

`default_nettype wire

// >>> timer_capture_pwm_control_properties.sv
// checker: port-level assertions for the timer control block
`timescale 1ns/1ps
`default_nettype none
module timer_capture_pwm_control_properties
	import tcon_two_pkg::*;
(
	// clock, reset and bus
	input wire logic mclk,
	input wire logic srst,
	input wire logic [6:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	// pins, gating and interrupt
	input wire logic firstPulsePinOe_n,
	input wire logic secondPulsePinOe_n,
	input wire timer_gate_t timerGate,
	input wire logic irq
);
	// ==========================================
	// shadow of control and config bits
	logic [7:0] ctrl_ff;
	logic [7:0] cfg_ff;
	logic wrOk;
	// a write lands at the edge that ends its wait
	assign wrOk = write && !waitrequest && byteenable[0];
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ctrl_ff <= CTRL_RESET;
			cfg_ff <= CFG_RESET;
		end
		else if (wrOk && address[6:2] == IDX_TIMER_CONTROL_SECOND)
			ctrl_ff <= writedata[7:0] & CTRL_WRITE_MASK;
		else if (wrOk && address[6:2] == IDX_PORT_CONFIG)
			cfg_ff <= writedata[7:0] & CFG_WRITE_MASK;
	end
	// ==========================================
	// properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	sequence reqWaiting;
		(read || write) && waitrequest;
	endsequence
	sequence reqDone;
		(read || write) && !waitrequest;
	endsequence
	bus_answer_one_a: assert property (reqWaiting |=> reqDone)
		else $error("bus answer late");
	reset_gate_clear_a: assert property ($fell(srst) |-> timerGate == 4'h1 && !irq)
		else $error("gating not cleared by reset");
	second_pin_drive_a: assert property (ctrl_ff[5] |-> !secondPulsePinOe_n)
		else $error("second pin not driven");
	second_dir_follow_a: assert property (!ctrl_ff[5] |-> secondPulsePinOe_n == cfg_ff[3])
		else $error("second pin direction wrong");
	first_pin_drive_a: assert property (ctrl_ff[4] |-> !firstPulsePinOe_n)
		else $error("first pin not driven");
	first_dir_follow_a: assert property (!ctrl_ff[4] |-> firstPulsePinOe_n == cfg_ff[2])
		else $error("first pin direction wrong");
	period_select_a: assert property (timerGate.periodLimit == !ctrl_ff[3])
		else $error("period limit wrong");
	timer_three_gate_a: assert property (timerGate.timerThreeInc == ctrl_ff[2])
		else $error("timer three gate wrong");
	timer_two_gate_a: assert property (timerGate.timerTwoInc
		== (cfg_ff[0] ? ctrl_ff[1] && ctrl_ff[0] : ctrl_ff[1]))
		else $error("timer two gate wrong");
	timer_one_gate_a: assert property (timerGate.timerOneInc == ctrl_ff[0])
		else $error("timer one gate wrong");
endmodule
`default_nettype wire

// >>> timer_capture_pwm_control_tb.sv
// testbench: bus, capture, pin and gating scenarios for the timer control block
`timescale 1ns/1ps
`default_nettype none
module timer_capture_pwm_control_tb
	import tcon_two_pkg::*;
;
	// ==========================================
	// design signals and bench state
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [6:0] address = 7'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] be = 4'hF;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [1:0] ev = 2'h0;
	logic [15:0] tCount = 16'h0;
	logic [1:0] lv = 2'h0;
	logic [1:0] pin = 2'h0;
	logic [1:0] pOut;
	logic [1:0] pOe;
	timer_gate_t gate;
	logic [15:0] period;
	logic irq;
	int bad_count = 0;
	int cmp_count = 0;
	logic [31:0] q;
	logic [7:0] c;
	logic [7:0] f;
	logic [15:0] v;
	// 40 MHz clock
	always #12.5 mclk = ~mclk;
	timer_capture_pwm_control DUT (
		.mclk(mclk), .srst(srst), .address(address), .read(read), .write(write),
		.byteenable(be), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .firstCaptureEvent(ev[0]),
		.secondCaptureEvent(ev[1]), .timerThreeCount(tCount),
		.firstPulseLevel(lv[0]), .secondPulseLevel(lv[1]), .timerGate(gate),
		.timerThreePeriod(period), .firstPulsePinIn(pin[0]),
		.firstPulsePinOut(pOut[0]), .firstPulsePinOe_n(pOe[0]),
		.secondPulsePinIn(pin[1]), .secondPulsePinOut(pOut[1]),
		.secondPulsePinOe_n(pOe[1]), .irq(irq)
	);
	// ==========================================
	// bus access: hold until waitrequest is seen low at a rising edge, then release
	task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] d);
		@(posedge mclk);
		write <= w;
		read <= !w;
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		// values read here are those the design sampled at this edge
		@(posedge mclk);
		while (waitrequest !== 1'b0)
			@(posedge mclk);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	// read a capture pair, low byte first
	task automatic pair(input int k);
		logic [7:0] lo;
		bus(1'b0, k ? IDX_SECOND_CAPTURE_LOW : IDX_SHARED_PAIR_LOW, 8'h00);
		lo = q[7:0];
		bus(1'b0, k ? IDX_SECOND_CAPTURE_HIGH : IDX_SHARED_PAIR_HIGH, 8'h00);
		q = {16'h0, q[7:0], lo};
	endtask
	// one-cycle capture pulse with a timer value
	task automatic cap(input int k, input logic [15:0] val);
		@(posedge mclk);
		tCount <= val;
		ev[k] <= 1'b1;
		@(posedge mclk);
		ev <= 2'h0;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// expected gating: one, two, three, period limit
	function automatic logic [3:0] gexp(input logic [7:0] cc, input logic p);
		return {cc[0], (p ? cc[0] & cc[1] : cc[1]), cc[2], ~cc[3]};
	endfunction
	task automatic tally_and_finish;
		$display("compares=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial
	begin
		repeat (5000) @(posedge mclk);
		bad_count++;
		tally_and_finish;
	end
	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'h62c82f07));
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		bus(1'b0, IDX_TIMER_CONTROL_SECOND, 8'h00);
		chk(q, 32'h0);
		bus(1'b0, IDX_PORT_CONFIG, 8'h00);
		chk(q, {24'h0, CFG_RESET});
		bus(1'b0, 5'h00, 8'h00);
		chk(q, 32'h0);
		$display("test reset done");
		// corners first, then random control and config
		for (int i = 0; i < 10; i++)
		begin
			c = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			f = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			lv <= 2'($urandom);
			pin <= 2'($urandom);
			bus(1'b1, IDX_PORT_CONFIG, f);
			bus(1'b1, IDX_TIMER_CONTROL_SECOND, c);
			bus(1'b0, IDX_TIMER_CONTROL_SECOND, 8'h00);
			chk(q, {24'h0, c & 8'h3F});
			chk(gate, gexp(c, f[0]));
			chk(pOe[0], c[4] ? 1'b0 : f[2]);
			chk(pOut[0], c[4] ? lv[0] : f[6]);
			chk(pOe[1], c[5] ? 1'b0 : f[3]);
			chk(pOut[1], c[5] ? lv[1] : f[7]);
			// config readback with synchronised pin levels
			bus(1'b0, IDX_PORT_CONFIG, 8'h00);
			chk(q, {24'h0, (f & 8'hCD) | {2'b00, pin, 4'h0}});
		end
		// lane zero disabled: write ignored
		be <= 4'h0;
		bus(1'b1, IDX_TIMER_CONTROL_SECOND, 8'h3F);
		be <= 4'hF;
		bus(1'b0, IDX_TIMER_CONTROL_SECOND, 8'h00);
		chk(q, {24'h0, c & 8'h3F});
		$display("test control done");
		// overrun on each capture pair
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, IDX_TIMER_CONTROL_SECOND, 8'h08);
			bus(1'b1, IDX_EVENT_MASK, 8'h0F);
			v = 16'($urandom);
			cap(k, v);
			@(negedge mclk);
			chk(irq, 1'b1);
			cap(k, ~v);
			cap(k, v ^ 16'h5A5A);
			bus(1'b0, IDX_TIMER_CONTROL_SECOND, 8'h00);
			chk(q[6 + k], 1'b1);
			bus(1'b0, IDX_EVENT_STATUS, 8'h00);
			chk(q, 32'h5 << k);
			pair(k);
			chk(q, v);
			bus(1'b0, IDX_TIMER_CONTROL_SECOND, 8'h00);
			chk(q[6 + k], 1'b0);
			cap(k, ~v);
			pair(k);
			chk(q, {16'h0, ~v});
			bus(1'b1, IDX_EVENT_MASK, 8'h00);
			@(negedge mclk);
			chk(irq, 1'b0);
			bus(1'b1, IDX_EVENT_STATUS, 8'h0F);
			bus(1'b0, IDX_EVENT_STATUS, 8'h00);
			chk(q, 32'h0);
			$display("test capture %0d done", k);
		end
		// period mode: pair is written, first capture ignored
		bus(1'b1, IDX_TIMER_CONTROL_SECOND, 8'h00);
		v = 16'($urandom);
		bus(1'b1, IDX_SHARED_PAIR_LOW, v[7:0]);
		bus(1'b1, IDX_SHARED_PAIR_HIGH, v[15:8]);
		cap(0, ~v);
		chk(period, v);
		pair(0);
		chk(q, v);
		bus(1'b0, IDX_EVENT_STATUS, 8'h00);
		chk(q, 32'h0);
		$display("test period done");
		// mid-run reset clears a fully set control register
		bus(1'b1, IDX_TIMER_CONTROL_SECOND, 8'h3F);
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		bus(1'b0, IDX_TIMER_CONTROL_SECOND, 8'h00);
		chk(q, 32'h0);
		chk(gate, 4'h1);
		chk(irq, 1'b0);
		$display("test midreset done");
		tally_and_finish;
	end
endmodule
bind timer_capture_pwm_control timer_capture_pwm_control_properties props (
	.mclk(mclk), .srst(srst), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .waitrequest(waitrequest),
	.firstPulsePinOe_n(firstPulsePinOe_n), .secondPulsePinOe_n(secondPulsePinOe_n),
	.timerGate(timerGate), .irq(irq)
);
`default_nettype wire
